// *** islp_map.svh ***
/*
 Constants for the I/O sampling and line passing block: reset values and
 timing counts. Assumes a 20 MHz core clock.
*/
`ifndef ISLP_MAP_SVH
`define ISLP_MAP_SVH
`define ISLP_CLK_HZ 20000000
`define ISLP_MS_TICK_NS 1000000
`define ISLP_MS_CYCLES (`ISLP_MS_TICK_NS / 50)
`define ISLP_TENTH_MS 100
`define ISLP_PWM_PERIOD_US 64
`define ISLP_PWM_STEP_CYCLES ((`ISLP_PWM_PERIOD_US * 20) / 1024)
`define ISLP_SIGNAL_PWM_TIMER_RST 8'h28
`define ISLP_HOLD_TIMEOUT_RST 8'hff
`define ISLP_TIMER_ALWAYS_ON 8'hff
`define ISLP_ANY_SOURCE 64'h0000_0000_0000_ffff
`define ISLP_PASSING_OFF 64'hffff_ffff_ffff_ffff
`define ISLP_PWM_CFG_SIGNAL 2'h1
`define ISLP_PWM_CFG_PWM 2'h2
`endif

// *** islp_pkg.sv ***
/*
 Types for the I/O sampling and line passing block.
 Assumes the constants header is included where numbers are needed.
*/
package islp_pkg;
	typedef enum logic [1:0] {
		ISLP_IDLE,
		ISLP_FLUSH,
		ISLP_SEND
	} islp_send_state_t;
	typedef enum logic [1:0] {
		ISLP_KIND_PERIODIC,
		ISLP_KIND_CHANGE
	} islp_kind_t;
endpackage

// *** islp_fifo.sv ***
/*
 Parameterised FIFO holding outgoing samples.
 Assumes one clock, asynchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module islp_fifo #(
	parameter int WIDTH = 34,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;
	////////////////////////////////////////////////////////////////////////
	always_comb begin
		in_ready = (count != (AW+1)'(DEPTH));
		out_valid = (count != '0);
		out_data = mem[rd_ptr];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule // islp_fifo
`default_nettype wire

// *** islp_core.sv ***
/*
 I/O sampling, line passing, hold timeouts and PWM outputs.
 Assumes configuration ports are static from the core clock domain and the
 received sample strobe comes from same-clock logic; line pins are async.
*/
`include "islp_map.svh"
`timescale 1ns/1ns
`default_nettype none
module islp_core #(
	parameter int LINES = 8,
	parameter int FIFO_DEPTH = 32,
	parameter int MS_CYCLES = `ISLP_MS_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Configuration
	input wire logic [15:0] change_monitor_mask,
	input wire logic [15:0] sample_interval,
	input wire logic [7:0] signal_pwm_timer,
	input wire logic [63:0] bound_source_address,
	input wire logic [63:0] line_hold_timeouts,
	input wire logic [7:0] pwm_hold_timeout,
	input wire logic [9:0] pwm_zero_duty,
	input wire logic [9:0] pwm_one_duty,
	input wire logic [1:0] pwm_zero_pin_config,
	input wire logic [1:0] pwm_one_pin_config,
	input wire logic sample_forward_enable,
	input wire logic [LINES-1:0] digital_input_enable,
	input wire logic [LINES-1:0] digital_output_enable,
	input wire logic [LINES-1:0] digital_default_level,
	input wire logic [1:0] analog_input_enable,
	// Local pins
	input wire logic [LINES-1:0] digital_line_pin,
	input wire logic [9:0] analog_channel_zero,
	input wire logic [9:0] analog_channel_one,
	output logic [LINES-1:0] digital_line_out,
	output logic pwm_output_zero,
	output logic pwm_output_one,
	// Outgoing samples
	output logic tx_valid,
	input wire logic tx_ready,
	output logic tx_change_only,
	output logic [LINES-1:0] tx_digital,
	output logic [9:0] tx_analog_zero,
	output logic [9:0] tx_analog_one,
	output logic sample_dropped,
	// Received samples
	input wire logic rx_valid,
	input wire logic [63:0] rx_source,
	input wire logic rx_to_us,
	input wire logic [LINES-1:0] rx_digital,
	input wire logic [9:0] rx_analog_zero,
	input wire logic [9:0] rx_analog_one,
	input wire logic [7:0] rx_signal_strength,
	output logic host_forward_valid
);
	localparam int WIDTH = 1 + LINES + 20;
	logic [LINES-1:0] pin_meta, pin_sync, prev_pins, next_prev_pins;
	logic [15:0] ms_div, next_ms_div, interval_cnt, next_interval_cnt;
	logic [6:0] tenth_cnt, next_tenth_cnt;
	logic ms_tick, tenth_tick, periodic_on, periodic_due, change_hit;
	logic q_valid, q_ready, q_change;
	logic [WIDTH-1:0] q_data;
	islp_pkg::islp_send_state_t state, next_state;
	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser and time base
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= digital_line_pin;
			pin_sync <= pin_meta;
		end
	end
	always_comb begin
		ms_tick = (ms_div == 16'(MS_CYCLES - 1));
		next_ms_div = ms_tick ? 16'h0000 : ms_div + 16'h0001;
		tenth_tick = ms_tick && (tenth_cnt == 7'(`ISLP_TENTH_MS - 1));
		next_tenth_cnt = tenth_tick ? 7'h00 : (ms_tick ? tenth_cnt + 7'h01 : tenth_cnt);
		periodic_on = (sample_interval != 16'h0000) && ((|digital_input_enable) || (|analog_input_enable));
		periodic_due = 1'b0;
		next_interval_cnt = interval_cnt;
		if (!periodic_on) begin
			next_interval_cnt = 16'h0000;
		end else if (ms_tick) begin
			if (interval_cnt + 16'h0001 >= sample_interval) begin
				periodic_due = 1'b1;
				next_interval_cnt = 16'h0000;
			end else begin
				next_interval_cnt = interval_cnt + 16'h0001;
			end
		end
		change_hit = |((pin_sync ^ prev_pins) & change_monitor_mask[LINES-1:0] & digital_input_enable);
		next_prev_pins = pin_sync;
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ms_div <= '0;
			tenth_cnt <= '0;
			interval_cnt <= '0;
			prev_pins <= '0;
		end else begin
			ms_div <= next_ms_div;
			tenth_cnt <= next_tenth_cnt;
			interval_cnt <= next_interval_cnt;
			prev_pins <= next_prev_pins;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Sample queue; a change waits for the queue to drain first
	always_comb begin
		next_state = state;
		q_valid = 1'b0;
		q_change = 1'b0;
		unique case (state)
			islp_pkg::ISLP_IDLE: begin
				if (change_hit) begin
					next_state = islp_pkg::ISLP_FLUSH;
				end else if (periodic_due) begin
					q_valid = 1'b1;
				end
			end
			islp_pkg::ISLP_FLUSH: begin
				if (!tx_valid) begin
					next_state = islp_pkg::ISLP_SEND;
				end
			end
			islp_pkg::ISLP_SEND: begin
				q_valid = 1'b1;
				q_change = 1'b1;
				if (q_ready) begin
					next_state = islp_pkg::ISLP_IDLE;
				end
			end
		endcase
		q_data = {q_change, pin_sync & digital_input_enable,
			q_change ? 10'h000 : (analog_input_enable[0] ? analog_channel_zero : 10'h000),
			q_change ? 10'h000 : (analog_input_enable[1] ? analog_channel_one : 10'h000)};
		sample_dropped = periodic_due && !(q_valid && q_ready);
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state <= islp_pkg::ISLP_IDLE;
		end else begin
			state <= next_state;
		end
	end
	islp_fifo #(.WIDTH(WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.reset(reset),
		.in_valid(q_valid),
		.in_ready(q_ready),
		.in_data(q_data),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data({tx_change_only, tx_digital, tx_analog_zero, tx_analog_one})
	);
	////////////////////////////////////////////////////////////////////////
	// Line passing with hold timers
	logic accept, pwm_output_zero_mode, pwm_output_one_mode;
	logic [LINES-1:0] held, next_held;
	logic [7:0] hold_cnt [LINES];
	logic [7:0] next_hold_cnt [LINES];
	logic [9:0] duty0, duty1, next_duty0, next_duty1;
	logic [7:0] pwm_cnt, next_pwm_cnt, sig_cnt, next_sig_cnt;
	logic [7:0] sig_duty, next_sig_duty;
	logic sig_on, next_sig_on, next_fwd;
	always_comb begin
		accept = rx_valid && rx_to_us && (bound_source_address != `ISLP_PASSING_OFF)
			&& ((bound_source_address == `ISLP_ANY_SOURCE) || (rx_source == bound_source_address));
		pwm_output_zero_mode = (pwm_zero_pin_config == `ISLP_PWM_CFG_PWM);
		pwm_output_one_mode = (pwm_one_pin_config == `ISLP_PWM_CFG_PWM);
		next_fwd = accept && sample_forward_enable;
		next_duty0 = pwm_output_zero_mode ? duty0 : pwm_zero_duty;
		next_duty1 = pwm_output_one_mode ? duty1 : pwm_one_duty;
		next_pwm_cnt = pwm_cnt;
		if (accept && (pwm_output_zero_mode || pwm_output_one_mode)) begin
			if (pwm_output_zero_mode) next_duty0 = rx_analog_zero;
			if (pwm_output_one_mode) next_duty1 = rx_analog_one;
			next_pwm_cnt = pwm_hold_timeout;
		end else if (tenth_tick && pwm_cnt != 8'h00 && pwm_hold_timeout != 8'h00) begin
			next_pwm_cnt = pwm_cnt - 8'h01;
			if (pwm_cnt == 8'h01) begin
				next_duty0 = pwm_zero_duty;
				next_duty1 = pwm_one_duty;
			end
		end
		next_sig_duty = sig_duty;
		next_sig_on = sig_on;
		next_sig_cnt = sig_cnt;
		if (rx_valid && rx_to_us) begin
			next_sig_duty = rx_signal_strength;
			next_sig_on = 1'b1;
			next_sig_cnt = signal_pwm_timer;
		end else if (signal_pwm_timer == `ISLP_TIMER_ALWAYS_ON) begin
			next_sig_cnt = sig_cnt;
		end else if (tenth_tick && sig_on) begin
			if (sig_cnt <= 8'h01) next_sig_on = 1'b0;
			else next_sig_cnt = sig_cnt - 8'h01;
		end
	end
	for (genvar i = 0; i < LINES; i++) begin : g_line
		logic next_out;
		always_comb begin
			next_held[i] = held[i];
			next_hold_cnt[i] = hold_cnt[i];
			if (accept) begin
				next_held[i] = rx_digital[i];
				next_hold_cnt[i] = line_hold_timeouts[8*i +: 8];
			end else if (tenth_tick && hold_cnt[i] != 8'h00 && line_hold_timeouts[8*i +: 8] != 8'h00) begin
				next_hold_cnt[i] = hold_cnt[i] - 8'h01;
				if (hold_cnt[i] == 8'h01) next_held[i] = digital_default_level[i];
			end
			next_out = digital_output_enable[i] ? next_held[i] : 1'b0;
		end
		always_ff @(posedge core_clk or posedge reset) begin
			if (reset) begin
				held[i] <= 1'b0;
				hold_cnt[i] <= 8'h00;
				digital_line_out[i] <= 1'b0;
			end else begin
				held[i] <= next_held[i];
				hold_cnt[i] <= next_hold_cnt[i];
				digital_line_out[i] <= next_out;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// PWM generation, 1024 duty steps (256 for the signal strength output) spread over a 64 us period
	localparam int PWM_PERIOD = `ISLP_PWM_PERIOD_US * (`ISLP_CLK_HZ / 1000000);
	logic [10:0] phase, next_phase, level0, level1, level_sig;
	logic next_pwm_zero, next_pwm_one;
	always_comb begin
		next_phase = (phase == 11'(PWM_PERIOD - 1)) ? 11'h000 : phase + 11'h001;
		// Duty scaled by 5/4 so the 1024 steps cover the whole period
		level0 = {1'b0, duty0} + {3'b000, duty0[9:2]};
		level1 = {1'b0, duty1} + {3'b000, duty1[9:2]};
		level_sig = {1'b0, sig_duty, 2'b00} + {3'b000, sig_duty};
		if (pwm_zero_pin_config == `ISLP_PWM_CFG_SIGNAL) begin
			next_pwm_zero = sig_on && (level_sig > phase);
		end else begin
			next_pwm_zero = pwm_output_zero_mode && ((duty0 == 10'h3ff) || (level0 > phase));
		end
		next_pwm_one = pwm_output_one_mode && ((duty1 == 10'h3ff) || (level1 > phase));
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			duty0 <= '0;
			duty1 <= '0;
			pwm_cnt <= '0;
			sig_duty <= '0;
			sig_on <= 1'b0;
			sig_cnt <= `ISLP_SIGNAL_PWM_TIMER_RST;
			phase <= '0;
			host_forward_valid <= 1'b0;
			pwm_output_zero <= 1'b0;
			pwm_output_one <= 1'b0;
		end else begin
			duty0 <= next_duty0;
			duty1 <= next_duty1;
			pwm_cnt <= next_pwm_cnt;
			sig_duty <= next_sig_duty;
			sig_on <= next_sig_on;
			sig_cnt <= next_sig_cnt;
			phase <= next_phase;
			host_forward_valid <= next_fwd;
			pwm_output_zero <= next_pwm_zero;
			pwm_output_one <= next_pwm_one;
		end
	end
endmodule // islp_core
`default_nettype wire

// *** islp_checker.sv ***
/*
 Port assertions for islp_core.
 Assumes the bind below and one core clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "islp_map.svh"
module islp_checker (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Configuration
	input wire logic [63:0] bound_source_address,
	input wire logic [7:0] digital_output_enable,
	input wire logic [1:0] pwm_zero_pin_config,
	input wire logic [1:0] pwm_one_pin_config,
	input wire logic sample_forward_enable,
	// Outputs
	input wire logic [7:0] digital_line_out,
	input wire logic pwm_output_zero,
	input wire logic pwm_output_one,
	input wire logic host_forward_valid,
	// Outgoing samples
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic tx_change_only,
	input wire logic [7:0] tx_digital,
	input wire logic [9:0] tx_analog_zero,
	input wire logic [9:0] tx_analog_one,
	// Received samples
	input wire logic rx_valid,
	input wire logic [63:0] rx_source,
	input wire logic rx_to_us,
	input wire logic [7:0] rx_digital,
	input wire logic [9:0] rx_analog_zero,
	input wire logic [9:0] rx_analog_one
);
	logic acc;
	logic fwd;
	assign acc = rx_valid && rx_to_us && bound_source_address != `ISLP_PASSING_OFF &&
		(rx_source == bound_source_address || bound_source_address == `ISLP_ANY_SOURCE);
	assign fwd = acc && sample_forward_enable;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////
	a_digital_pass: assert property (acc |=> ((digital_line_out ^ $past(rx_digital)) & digital_output_enable) == 8'h00)
		else $error("digital output differs from passed sample");
	a_passing_off: assert property (rx_valid && bound_source_address == `ISLP_PASSING_OFF |=> $stable(digital_line_out))
		else $error("output changed while passing is off");
	a_fwd_pulse: assert property (fwd |=> host_forward_valid)
		else $error("received sample not forwarded");
	a_fwd_cause: assert property (host_forward_valid |-> $past(fwd))
		else $error("forward pulse without accepted sample");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_digital) && $stable(tx_change_only))
		else $error("queued sample lost or changed while stalled");
	a_change_no_analog: assert property (tx_valid && tx_change_only |-> tx_analog_zero == 10'h000 && tx_analog_one == 10'h000)
		else $error("change sample carries analog data");
	a_pwm_full: assert property (acc && pwm_zero_pin_config == `ISLP_PWM_CFG_PWM && rx_analog_zero == 10'h3ff |-> ##3 pwm_output_zero [*8])
		else $error("pwm zero not at full duty");
	a_pwm_dark: assert property (acc && pwm_one_pin_config == `ISLP_PWM_CFG_PWM && rx_analog_one == 10'h000 |-> ##3 !pwm_output_one [*8])
		else $error("pwm one not at zero duty");
endmodule // islp_checker
bind islp_core islp_checker i_islp_checker (.core_clk, .reset, .bound_source_address, .digital_output_enable,
	.pwm_zero_pin_config, .pwm_one_pin_config, .sample_forward_enable, .digital_line_out, .pwm_output_zero,
	.pwm_output_one, .host_forward_valid, .tx_valid, .tx_ready, .tx_change_only, .tx_digital, .tx_analog_zero,
	.tx_analog_one, .rx_valid, .rx_source, .rx_to_us, .rx_digital, .rx_analog_zero, .rx_analog_one);
`default_nettype wire

// *** islp_remote_node.sv ***
/*
 Remote node: sends sample packets, drains outgoing samples.
 Assumes it is driven from the testbench at falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
module islp_remote_node (
	// Clock
	input wire logic core_clk,
	// Samples toward the core
	output logic rx_valid,
	output logic [63:0] rx_source,
	output logic rx_to_us,
	output logic [7:0] rx_digital,
	output logic [9:0] rx_analog_zero,
	output logic [9:0] rx_analog_one,
	output logic [7:0] rx_signal_strength,
	// Drain side
	output logic tx_ready
);
	logic stall = 1'b0;
	assign tx_ready = !stall;
	initial begin
		rx_valid = 1'b0;
		{rx_source, rx_to_us, rx_digital, rx_analog_zero, rx_analog_one, rx_signal_strength} = '0;
	end
	task automatic send(input logic [63:0] s, input logic t, input logic [7:0] d, input logic [9:0] a, b,
		input logic [7:0] q);
		@(negedge core_clk);
		{rx_source, rx_to_us, rx_digital, rx_analog_zero, rx_analog_one, rx_signal_strength} = {s, t, d, a, b, q};
		rx_valid = 1'b1;
		@(negedge core_clk);
		rx_valid = 1'b0;
		// Source, digital and analog fields are not held once the packet is over
		{rx_source, rx_digital, rx_analog_zero, rx_analog_one} = ~{s, d, a, b};
	endtask
endmodule // islp_remote_node
`default_nettype wire

// *** io_sample_line_passing_tb.sv ***
/*
 Self-checking testbench for islp_core.
 Assumes MS_CYCLES of 20 so 100 ms is 2000 cycles.
*/
`timescale 1ns/1ns
`default_nettype none
`include "islp_map.svh"
module io_sample_line_passing_tb;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [15:0] change_monitor_mask, sample_interval;
	logic [7:0] signal_pwm_timer, pwm_hold_timeout, digital_input_enable, digital_output_enable;
	logic [7:0] digital_default_level, digital_line_pin, digital_line_out, tx_digital, rx_digital, rx_signal_strength;
	logic [63:0] bound_source_address, line_hold_timeouts, rx_source;
	logic [9:0] pwm_zero_duty, pwm_one_duty, analog_channel_zero, analog_channel_one;
	logic [9:0] tx_analog_zero, tx_analog_one, rx_analog_zero, rx_analog_one;
	logic [1:0] pwm_zero_pin_config, pwm_one_pin_config, analog_input_enable;
	logic sample_forward_enable, pwm_output_zero, pwm_output_one, tx_valid, tx_ready, tx_change_only;
	logic sample_dropped, rx_valid, rx_to_us, host_forward_valid;
	int mismatches = 0, num_checks = 0, cyc = 0, drops = 0, n0, n1, k, t0;
	localparam logic [63:0] SRC = 64'h0000_0000_1234_5678;
	localparam int PWM_PERIOD = `ISLP_PWM_PERIOD_US * (`ISLP_CLK_HZ / 1000000);
	islp_core #(.MS_CYCLES(20)) i_islp_core (.core_clk, .reset, .change_monitor_mask, .sample_interval,
		.signal_pwm_timer, .bound_source_address, .line_hold_timeouts, .pwm_hold_timeout, .pwm_zero_duty,
		.pwm_one_duty, .pwm_zero_pin_config, .pwm_one_pin_config, .sample_forward_enable, .digital_input_enable,
		.digital_output_enable, .digital_default_level, .analog_input_enable, .digital_line_pin,
		.analog_channel_zero, .analog_channel_one, .digital_line_out, .pwm_output_zero, .pwm_output_one,
		.tx_valid, .tx_ready, .tx_change_only, .tx_digital, .tx_analog_zero, .tx_analog_one, .sample_dropped,
		.rx_valid, .rx_source, .rx_to_us, .rx_digital, .rx_analog_zero, .rx_analog_one, .rx_signal_strength,
		.host_forward_valid);
	islp_remote_node i_islp_remote_node (.core_clk, .rx_valid, .rx_source, .rx_to_us, .rx_digital,
		.rx_analog_zero, .rx_analog_one, .rx_signal_strength, .tx_ready);
	////////////////////////////////////////
	initial forever #25 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (sample_dropped === 1'b1) drops <= drops + 1;
		if (cyc == 60000) begin
			mismatches++;
			test_done;
		end
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic measure;
		n0 = 0;
		n1 = 0;
		repeat (PWM_PERIOD) begin
			@(negedge core_clk);
			n0 += pwm_output_zero;
			n1 += pwm_output_one;
		end
	endtask
	task automatic wait_tx;
		k = 0;
		while (tx_valid !== 1'b1 && k < 400) begin
			@(negedge core_clk);
			k++;
		end
		chk(tx_valid, 1'b1);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		{change_monitor_mask, sample_interval, line_hold_timeouts, pwm_hold_timeout, pwm_zero_duty, pwm_one_duty} = '0;
		{digital_input_enable, digital_default_level, analog_input_enable, digital_line_pin} = '0;
		{pwm_zero_pin_config, pwm_one_pin_config} = '0;
		analog_channel_zero = 10'h155;
		analog_channel_one = 10'h2aa;
		signal_pwm_timer = `ISLP_SIGNAL_PWM_TIMER_RST;
		bound_source_address = `ISLP_PASSING_OFF;
		sample_forward_enable = 1'b1;
		digital_output_enable = 8'hff;
		repeat (2) @(negedge core_clk);
		reset = 1'b0;
		chk({digital_line_out, tx_valid, pwm_output_zero, pwm_output_one}, '0);
		$display("test reset done");
		bound_source_address = SRC;
		i_islp_remote_node.send(SRC, 1'b1, 8'ha5, 10'h000, 10'h000, 8'h00);
		chk(host_forward_valid, 1'b1);
		chk(digital_line_out, 8'ha5);
		i_islp_remote_node.send(SRC + 1, 1'b1, 8'h5a, 10'h000, 10'h000, 8'h00);
		chk(digital_line_out, 8'ha5);
		bound_source_address = `ISLP_ANY_SOURCE;
		i_islp_remote_node.send(SRC + 1, 1'b1, 8'h3c, 10'h000, 10'h000, 8'h00);
		chk(digital_line_out, 8'h3c);
		i_islp_remote_node.send(SRC + 1, 1'b0, 8'h0f, 10'h000, 10'h000, 8'h00);
		chk(digital_line_out, 8'h3c);
		bound_source_address = `ISLP_PASSING_OFF;
		i_islp_remote_node.send(`ISLP_PASSING_OFF, 1'b1, 8'h00, 10'h000, 10'h000, 8'h00);
		chk(digital_line_out, 8'h3c);
		$display("test passing done");
		bound_source_address = SRC;
		line_hold_timeouts = 64'h0000_0000_0000_0002;
		i_islp_remote_node.send(SRC, 1'b1, 8'h03, 10'h000, 10'h000, 8'h00);
		repeat (1900) @(negedge core_clk);
		chk(digital_line_out, 8'h03);
		i_islp_remote_node.send(SRC, 1'b1, 8'h03, 10'h000, 10'h000, 8'h00);
		repeat (1900) @(negedge core_clk);
		chk(digital_line_out, 8'h03);
		repeat (2200) @(negedge core_clk);
		chk(digital_line_out, 8'h02);
		$display("test hold done");
		{pwm_zero_pin_config, pwm_one_pin_config} = {`ISLP_PWM_CFG_PWM, `ISLP_PWM_CFG_PWM};
		pwm_hold_timeout = 8'h03;
		i_islp_remote_node.send(SRC, 1'b1, 8'h00, 10'h3ff, 10'h000, 8'h00);
		measure;
		chk(n0, PWM_PERIOD);
		chk(n1, 0);
		i_islp_remote_node.send(SRC, 1'b1, 8'h00, 10'h1ff, 10'h3ff, 8'h00);
		measure;
		chk(n0 >= PWM_PERIOD / 2 - 8 && n0 <= PWM_PERIOD / 2 + 8, 1'b1);
		chk(n1, PWM_PERIOD);
		repeat (6100) @(negedge core_clk);
		measure;
		chk({n0, n1}, 0);
		$display("test pwm done");
		pwm_zero_pin_config = `ISLP_PWM_CFG_SIGNAL;
		signal_pwm_timer = `ISLP_TIMER_ALWAYS_ON;
		i_islp_remote_node.send(SRC, 1'b1, 8'h00, 10'h000, 10'h000, 8'hff);
		repeat (6000) @(negedge core_clk);
		measure;
		chk(n0 >= PWM_PERIOD - 8, 1'b1);
		signal_pwm_timer = 8'h01;
		i_islp_remote_node.send(SRC, 1'b1, 8'h00, 10'h000, 10'h000, 8'hff);
		repeat (4100) @(negedge core_clk);
		measure;
		chk(n0, 0);
		$display("test signal pwm done");
		digital_input_enable = 8'h01;
		change_monitor_mask = 16'h0001;
		repeat (5) @(negedge core_clk);
		digital_line_pin = 8'h01;
		wait_tx;
		chk({tx_change_only, tx_digital[0]}, 2'h3);
		@(negedge core_clk);
		chk(tx_valid, 1'b0);
		change_monitor_mask = 16'h0000;
		$display("test change done");
		digital_input_enable = 8'hff;
		analog_input_enable = 2'h3;
		sample_interval = 16'h0005;
		wait_tx;
		chk({tx_change_only, tx_analog_zero, tx_analog_one}, {1'b0, 10'h155, 10'h2aa});
		t0 = cyc;
		@(negedge core_clk);
		wait_tx;
		chk(cyc - t0, 100);
		i_islp_remote_node.stall = 1'b1;
		repeat (3600) @(negedge core_clk);
		sample_interval = 16'h0000;
		chk(drops > 0, 1'b1);
		i_islp_remote_node.stall = 1'b0;
		n0 = 0;
		while (tx_valid === 1'b1 && n0 < 100) begin
			@(negedge core_clk);
			n0++;
		end
		chk(n0 >= 32 && tx_valid === 1'b0, 1'b1);
		$display("test periodic done");
		sample_interval = 16'h0005;
		change_monitor_mask = 16'h0001;
		i_islp_remote_node.stall = 1'b1;
		repeat (250) @(negedge core_clk);
		digital_line_pin = 8'h00;
		repeat (10) @(negedge core_clk);
		sample_interval = 16'h0000;
		i_islp_remote_node.stall = 1'b0;
		n1 = 0;
		k = 0;
		while (!(tx_valid === 1'b1 && tx_change_only === 1'b1) && k < 60) begin
			n1 += (tx_valid === 1'b1);
			@(negedge core_clk);
			k++;
		end
		chk(n1 >= 2, 1'b1);
		chk({tx_valid, tx_change_only, tx_digital[0]}, 3'h6);
		$display("test order done");
		test_done;
	end
endmodule // io_sample_line_passing_tb
`default_nettype wire
